// *** rtl/crc16_crc32_engine.sv ***
/*
  byte-serial crc engine with indirect result access and automatic
  flash sector runs that stall the processor.
  assumes: register port accesses are single-cycle strobes from the core;
  flash answers each one-cycle read with flash_valid some cycles later.
*/
// What this block does
// - 32-bit mode uses reflected 0x04C11DB7 algorithm
// - 32-bit: xor byte into low byte
// - 32-bit: eight right shifts, conditional xor
// - select bit picks polynomial and length
// - init loads zeros or ones per seed
// - each input write folds byte immediately
// - auto run covers count sectors of 1024
// - control write starts run; core stalled
// - pointer picks result byte, auto-increments
// - 32-bit pointer maps four bytes
// - 16-bit pointer maps two bytes twice
// - result holds until init, write, input, auto-run flash fold
// - control bits 7:5 read zero
// - 16-bit: xor high byte, left shifts
// - first flash byte at start times 1024
module crc16_crc32_engine
  import crc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic [FADDR_W-1:0] flash_addr,
  output logic flash_rd,
  input wire logic flash_valid,
  input wire logic [7:0] flash_rdata,
  output logic cpu_stall
);
  typedef struct packed {
    run_e state;
    logic sel;
    logic val;
    logic [1:0] ptr;
    logic auto_en;
    logic [SECTOR_W-1:0] start;
    logic [SECTOR_W-1:0] count;
    logic [7:0] flip;
    logic [31:0] result;
    logic [FADDR_W-1:0] faddr;
    logic [FADDR_W:0] left;
    logic frd;
    logic stall;
    logic [7:0] rdata;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [1:0] byte_idx;
  logic [7:0] sel_byte;
  logic fold;

  crc_step_if step ();

  // ----------------------------------------
  // update path, shared by core and flash
  // ----------------------------------------
  assign step.crc_in = s_r.result;
  assign step.short_sel = s_r.sel;
  assign step.data = (s_r.state == st_wait) ? flash_rdata : sfr_wdata;

  crc_byte_update u_update (
    .p(step.calc)
  );

  // 16-bit mode only looks at the pointer's low bit
  assign byte_idx = s_r.sel ? {1'b0, s_r.ptr[0]} : s_r.ptr;
  assign sel_byte = s_r.result[byte_idx*8 +: 8];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.frd = 1'b0;
    fold = 1'b0;
    case (s_r.state)
      st_idle: begin
        // register accesses only land here: the core is stalled during runs
        if (sfr_wr) begin
          if (sfr_addr == ADDR_CTRL) begin
            s_nxt.sel = sfr_wdata[CTRL_SEL];
            s_nxt.val = sfr_wdata[CTRL_VAL];
            s_nxt.ptr = sfr_wdata[1:0];
            if (sfr_wdata[CTRL_INIT]) begin
              s_nxt.result = sfr_wdata[CTRL_VAL] ? SEED_ONES : SEED_ZERO;
            end
            if (s_r.auto_en && s_r.count != '0) begin
              s_nxt.state = st_fetch;
              s_nxt.stall = 1'b1;
              s_nxt.faddr = {s_r.start, SECTOR_SHIFT'(0)};
              s_nxt.left = {1'b0, s_r.count, SECTOR_SHIFT'(0)};
            end
          end else if (sfr_addr == ADDR_IN) begin
            fold = 1'b1;
          end else if (sfr_addr == ADDR_DATA) begin
            s_nxt.result[byte_idx*8 +: 8] = sfr_wdata;
          end else if (sfr_addr == ADDR_FLIP) begin
            s_nxt.flip = {<<{sfr_wdata}};
          end else if (sfr_addr == ADDR_AUTO) begin
            s_nxt.auto_en = sfr_wdata[AUTO_EN];
            s_nxt.start = sfr_wdata[SECTOR_W-1:0];
          end else if (sfr_addr == ADDR_CNT) begin
            s_nxt.count = sfr_wdata[SECTOR_W-1:0];
          end
        end
        if (sfr_rd) begin
          if (sfr_addr == ADDR_CTRL) begin
            s_nxt.rdata = {3'h0, s_r.sel, 1'b0, s_r.val, s_r.ptr};
          end else if (sfr_addr == ADDR_DATA) begin
            s_nxt.rdata = sel_byte;
          end else if (sfr_addr == ADDR_FLIP) begin
            s_nxt.rdata = s_r.flip;
          end else if (sfr_addr == ADDR_AUTO) begin
            s_nxt.rdata = {s_r.auto_en, 1'b1, s_r.start};
          end else if (sfr_addr == ADDR_CNT) begin
            s_nxt.rdata = {2'h0, s_r.count};
          end else begin
            s_nxt.rdata = 8'h00;
          end
        end
        if ((sfr_rd || sfr_wr) && sfr_addr == ADDR_DATA) begin
          s_nxt.ptr = s_r.ptr + 2'h1;
        end
      end
      st_fetch: begin
        s_nxt.frd = 1'b1;
        s_nxt.state = st_wait;
      end
      st_wait: begin
        if (flash_valid) begin
          fold = 1'b1;
          s_nxt.faddr = s_r.faddr + FADDR_W'(1);
          s_nxt.left = s_r.left - (FADDR_W + 1)'(1);
          if (s_r.left == (FADDR_W + 1)'(1)) begin
            s_nxt.state = st_idle;
            s_nxt.stall = 1'b0;
          end else begin
            s_nxt.state = st_fetch;
          end
        end
      end
      default: begin
        s_nxt.state = st_idle;
      end
    endcase
    if (fold) begin
      s_nxt.result = step.crc_out;
    end
  end

  // ----------------------------------------
  // state register, frozen while ce is low
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{state: st_idle, sel: CTRL_RESET[CTRL_SEL], val: CTRL_RESET[CTRL_VAL],
               ptr: CTRL_RESET[1:0], auto_en: AUTO_RESET[AUTO_EN], start: '0, count: '0,
               flip: 8'h00, result: SEED_ZERO, faddr: '0, left: '0, frd: 1'b0,
               stall: 1'b0, rdata: 8'h00};
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign sfr_rdata = s_r.rdata;
  assign flash_addr = s_r.faddr;
  assign flash_rd = s_r.frd;
  assign cpu_stall = s_r.stall;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic idle_ok;
  assign idle_ok = ce && s_r.state == st_idle;

  sequence s_start;
    idle_ok && sfr_wr && sfr_addr == ADDR_CTRL && s_r.auto_en && s_r.count != '0;
  endsequence

  a_init_zero_seed: assert property (idle_ok && sfr_wr && sfr_addr == ADDR_CTRL
      && sfr_wdata[CTRL_INIT] && !sfr_wdata[CTRL_VAL] |=> s_r.result == SEED_ZERO)
    else $error("init with seed 0 did not clear result");
  a_init_ones_seed: assert property (idle_ok && sfr_wr && sfr_addr == ADDR_CTRL
      && sfr_wdata[CTRL_INIT] && sfr_wdata[CTRL_VAL] |=> s_r.result == SEED_ONES)
    else $error("init with seed 1 did not set result");
  a_ptr_auto_inc: assert property (idle_ok && sfr_rd && !sfr_wr && sfr_addr == ADDR_DATA
      |=> s_r.ptr == $past(s_r.ptr) + 2'h1)
    else $error("pointer did not advance");
  a_map_wide_top: assert property (idle_ok && sfr_rd && !sfr_wr && sfr_addr == ADDR_DATA
      && !s_r.sel && s_r.ptr == 2'h3 |=> sfr_rdata == $past(s_r.result[31:24]))
    else $error("wide pointer 3 not mapped to bits 31:24");
  a_map_short_wrap: assert property (idle_ok && sfr_rd && !sfr_wr && sfr_addr == ADDR_DATA
      && s_r.sel && s_r.ptr == 2'h2 |=> sfr_rdata == $past(s_r.result[7:0]))
    else $error("short pointer 2 not mapped to bits 7:0");
  a_ctrl_unused_zero: assert property (idle_ok && sfr_rd && sfr_addr == ADDR_CTRL
      |=> sfr_rdata[7:5] == 3'h0)
    else $error("control bits 7:5 not zero");
  a_result_hold: assert property (s_r.state == st_idle && !(sfr_wr && (sfr_addr == ADDR_CTRL
      || sfr_addr == ADDR_IN || sfr_addr == ADDR_DATA)) |=> $stable(s_r.result))
    else $error("result changed without cause");
  a_run_stalls_core: assert property (s_start |=> cpu_stall && s_r.state == st_fetch
      ##1 (cpu_stall && flash_rd))
    else $error("auto run did not stall core and fetch");
  a_first_sector_addr: assert property (s_start |=> flash_addr ==
      {$past(s_r.start), SECTOR_SHIFT'(0)})
    else $error("first flash address not start sector base");
  a_flash_ascends: assert property (ce && s_r.state == st_wait && flash_valid
      |=> flash_addr == $past(flash_addr) + FADDR_W'(1))
    else $error("flash address did not ascend");
endmodule

// *** rtl/crc_pkg.sv ***
/*
  constants of the byte-serial crc engine: register addresses, field
  positions, reset values, polynomials and flash geometry.
  assumes: imported whole by every design file of the engine except the step interface.
*/
package crc_pkg;
  // ----------------------------------------
  // register addresses on the register port
  // ----------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'h91;
  localparam logic [7:0] ADDR_CTRL = 8'h92;
  localparam logic [7:0] ADDR_IN = 8'h93;
  localparam logic [7:0] ADDR_FLIP = 8'h95;
  localparam logic [7:0] ADDR_AUTO = 8'h96;
  localparam logic [7:0] ADDR_CNT = 8'h97;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_SEL = 4;
  localparam int CTRL_INIT = 3;
  localparam int CTRL_VAL = 2;
  localparam int AUTO_EN = 7;
  localparam int AUTO_DONE = 6;
  localparam int SECTOR_W = 6;
  // ----------------------------------------
  // reset values and seeds
  // ----------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] AUTO_RESET = 8'h40;
  localparam logic [31:0] SEED_ZERO = 32'h00000000;
  localparam logic [31:0] SEED_ONES = 32'hffffffff;
  // ----------------------------------------
  // polynomials (32-bit: reflected form of 32'h04c11db7; 16-bit: 16'h1021 unreflected)
  // ----------------------------------------
  localparam logic [31:0] POLY32_REFL = 32'hedb88320;
  localparam logic [15:0] POLY16 = 16'h1021;
  // ----------------------------------------
  // flash geometry
  // ----------------------------------------
  localparam int SECTOR_BYTES = 1024;
  localparam int SECTOR_SHIFT = $clog2(SECTOR_BYTES);
  localparam int FADDR_W = SECTOR_W + SECTOR_SHIFT;
  typedef enum logic [1:0] {st_idle, st_fetch, st_wait} run_e;
endpackage

// *** rtl/crc_step_if.sv ***
/*
  carrier between the engine and its byte update logic.
  assumes: one engine drives the inputs, one update block answers.
*/
interface crc_step_if;
  logic [31:0] crc_in;
  logic [7:0] data;
  logic short_sel;
  logic [31:0] crc_out;
  modport engine (output crc_in, output data, output short_sel, input crc_out);
  modport calc (input crc_in, input data, input short_sel, output crc_out);
endinterface

// *** rtl/crc_byte_update.sv ***
/*
  one input byte folded into the crc accumulator, purely combinational.
  assumes: engine registers the answer; upper half passes through in 16-bit mode.
*/
module crc_byte_update
  import crc_pkg::*;
(
  crc_step_if.calc p
);
  logic [31:0] acc;

  always_comb begin
    acc = p.crc_in;
    if (p.short_sel) begin
      acc[15:8] = acc[15:8] ^ p.data;
      for (int i = 0; i < 8; i++) begin
        if (acc[15]) begin
          acc[15:0] = {acc[14:0], 1'b0} ^ POLY16;
        end else begin
          acc[15:0] = {acc[14:0], 1'b0};
        end
      end
    end else begin
      // reflected form: no explicit bit reversal needed on byte or result
      acc[7:0] = acc[7:0] ^ p.data;
      for (int i = 0; i < 8; i++) begin
        if (acc[0]) begin
          acc = (acc >> 1) ^ POLY32_REFL;
        end else begin
          acc = acc >> 1;
        end
      end
    end
    p.crc_out = acc;
  end
endmodule

// *** tb/flash_model.sv ***
/*
  behavioural program memory answering the engine's one-byte reads.
  assumes: one outstanding read; data is a fixed function of the address.
*/
module flash_model
  import crc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic flash_rd,
  input wire logic [FADDR_W-1:0] flash_addr,
  output logic flash_valid,
  output logic [7:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [FADDR_W-1:0] addr_r;
  logic [2:0] wait_r;
  // --------------------------------
  // answer after 1 or 4 cycles
  // --------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_r <= 3'h0;
      flash_valid <= 1'b0;
      flash_rdata <= 8'h00;
    end else begin
      flash_valid <= 1'b0;
      // idle data toggles so a stale byte is never mistaken for an answer
      flash_rdata <= ~flash_rdata;
      if (flash_rd) begin
        addr_r <= flash_addr;
        wait_r <= (flash_addr[1:0] == 2'h3) ? 3'h4 : 3'h1;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
        if (wait_r == 3'h1) begin
          flash_valid <= 1'b1;
          flash_rdata <= addr_r[7:0] ^ addr_r[15:8] ^ 8'h5a;
        end
      end
    end
  end
endmodule

// *** tb/test_crc16_crc32_engine.sv ***
/*
  self-checking bench of the crc engine: register port, folds, auto run.
  assumes: flash_model on the flash side; ce high except in one freeze check.
*/
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", n, e, g); bad_count++; end end
module test_crc16_crc32_engine
  import crc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, ce, sfr_wr, sfr_rd, flash_rd, flash_valid, cpu_stall, s, v;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_rdata, q, b;
  logic [FADDR_W-1:0] flash_addr, exp_addr, fa;
  logic [31:0] acc;
  logic [5:0] st;
  int bad_count = 0, compares = 0, seed = 67096, i, j, n;
  crc16_crc32_engine u_dut (.clk(clk), .nrst(nrst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_valid(flash_valid),
    .flash_rdata(flash_rdata), .cpu_stall(cpu_stall));
  flash_model u_flash (.clk(clk), .nrst(nrst), .flash_rd(flash_rd),
    .flash_addr(flash_addr), .flash_valid(flash_valid), .flash_rdata(flash_rdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [31:0] upd(logic [31:0] a, logic [7:0] d, logic sh);
    for (int k = 0; k < 8; k++) begin
      if (sh) begin
        if (k == 0) a[15:8] ^= d;
        a[15:0] = a[15] ? ({a[14:0], 1'b0} ^ POLY16) : {a[14:0], 1'b0};
      end else begin
        if (k == 0) a[7:0] ^= d;
        a = a[0] ? ((a >> 1) ^ POLY32_REFL) : (a >> 1);
      end
    end
    return a;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1 q = sfr_rdata;
  endtask
  task automatic check_result(input logic [1:0] p);
    logic [7:0] e;
    bus(1'b1, ADDR_CTRL, {3'b000, s, 1'b0, v, p});
    for (int k = 0; k < 4; k++) begin
      bus(1'b0, ADDR_DATA, 8'h00);
      e = s ? (p[0] ? acc[15:8] : acc[7:0]) : 8'(acc >> (8 * p));
      `CHK("result byte", e, q)
      p = p + 2'h1;
    end
    bus(1'b0, ADDR_CTRL, 8'h00);
    `CHK("control", {3'b000, s, 1'b0, v, p}, q)
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // flash reads must climb one byte at a time
  always @(posedge clk) begin
    if (flash_rd === 1'b1) begin
      `CHK("flash address", exp_addr, flash_addr)
      exp_addr = exp_addr + 1'b1;
    end
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {nrst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    ce = 1'b1;
    exp_addr = '0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, ADDR_AUTO, 8'h00);
    `CHK("auto reset", AUTO_RESET, q)
    bus(1'b0, ADDR_CNT, 8'h00);
    `CHK("count reset", 8'h00, q)
    bus(1'b1, ADDR_CTRL, 8'he0);
    bus(1'b0, ADDR_CTRL, 8'h00);
    `CHK("unused bits", CTRL_RESET, q)
    bus(1'b1, ADDR_CTRL, 8'h0c);
    bus(1'b1, ADDR_IN, 8'h63);
    {s, v, acc} = {2'b01, 32'hf9462090};
    check_result(2'h0);
    // known answer over three bytes from an all-ones seed
    bus(1'b1, ADDR_CTRL, 8'h0c);
    bus(1'b1, ADDR_IN, 8'haa);
    bus(1'b1, ADDR_IN, 8'hbb);
    bus(1'b1, ADDR_IN, 8'hcc);
    acc = 32'h41b207b3;
    check_result(2'h1);
    for (i = 0; i < 24; i++) begin
      {s, v} = 2'($random(seed));
      bus(1'b1, ADDR_CTRL, {3'b000, s, 1'b1, v, 2'b11});
      acc = v ? SEED_ONES : SEED_ZERO;
      n = $random(seed) & 7;
      for (j = 0; j < n; j++) begin
        b = 8'($random(seed));
        bus(1'b1, ADDR_IN, b);
        acc = upd(acc, b, s);
      end
      if (i % 3 == 1) begin
        // fresh byte: b may never have been set when no folds ran
        b = 8'($random(seed));
        bus(1'b1, ADDR_DATA, b);
        acc[s ? 15 : 31 -: 8] = b;
        bus(1'b0, ADDR_CTRL, 8'h00);
        `CHK("pointer after write", {3'b000, s, 1'b0, v, 2'b00}, q)
      end
      check_result(2'($random(seed)));
    end
    st = 6'($random(seed));
    bus(1'b1, ADDR_AUTO, {2'b10, st});
    // count still zero: a control write must not start a run
    bus(1'b1, ADDR_CTRL, 8'h0c);
    `CHK("no run", 1'b0, cpu_stall)
    bus(1'b1, ADDR_CNT, 8'h01);
    {s, v, acc, exp_addr} = {2'b01, SEED_ONES, st, 10'h000};
    for (j = 0; j < SECTOR_BYTES; j++) begin
      fa = exp_addr + FADDR_W'(j);
      b = fa[7:0] ^ fa[15:8] ^ 8'h5a;
      acc = upd(acc, b, 1'b0);
    end
    bus(1'b1, ADDR_CTRL, 8'h0c);
    @(posedge clk);
    #1 `CHK("stall", 1'b1, cpu_stall)
    bus(1'b1, ADDR_FLIP, 8'h01);
    bus(1'b1, ADDR_IN, 8'hff);
    for (j = 0; j < 20000 && cpu_stall !== 1'b0; j++) @(posedge clk);
    if (cpu_stall !== 1'b0) begin
      bad_count++;
    end else begin
      `CHK("run end", {st + 6'd1, 10'h000}, exp_addr)
      bus(1'b1, ADDR_AUTO, 8'h00);
      check_result(2'h2);
      bus(1'b1, ADDR_FLIP, 8'hc0);
      bus(1'b0, ADDR_FLIP, 8'h00);
      `CHK("bit reverse", 8'h03, q)
      // ce low must swallow a write entirely
      @(posedge clk);
      ce <= 1'b0;
      bus(1'b1, ADDR_FLIP, 8'h0f);
      @(posedge clk);
      ce <= 1'b1;
      bus(1'b0, ADDR_FLIP, 8'h00);
      `CHK("frozen write", 8'h03, q)
    end
    end_of_test;
  end
endmodule
